// >>> core/ohb_pkg.sv
// Shared constants for the overhead single-bit handler and its controller.
// Assumes both ends and the linking interface are compiled after this file.
package ohb_pkg;

	// ------------------------------------------------------------------
	// Overhead bit vector layout
	// ------------------------------------------------------------------
	localparam int NBITS = 12; // Overhead bits carried per superframe.
	localparam int POS_M41 = 0; // Activation-ready bit.
	localparam int POS_M42 = 1; // Deactivation notice bit.
	localparam int POS_M47 = 6; // Partial activation bit.
	localparam int M4_LSB = 0; // First bit of the M4 group (M41..M48).
	localparam int M4_W = 8; // Width of the M4 group.
	localparam int ADD_LSB = 8; // First additional bit (M51, M52, M61).
	localparam int ADD_W = 3; // Width of the additional group.
	localparam int POS_M62 = 11; // Far-end block error bit.
	localparam logic [11:0] RST_TX_BITS = 12'hfff; // Unwritten bits send one.

	// ------------------------------------------------------------------
	// Local command message encoding
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_HDR = 8'h80; // Header, register-select zero.
	localparam logic [7:0] CMD_FILT_MASK = 8'hfc; // Clears the filter field.
	localparam logic [7:0] CMD_M4_BASE = 8'h8c; // M4 group filter codes.
	localparam logic [7:0] CMD_ADD_BASE = 8'h88; // Additional bit filter codes.
	localparam logic [7:0] CMD_PART_EXT = 8'h90; // Partial bit from messages.
	localparam logic [7:0] CMD_PART_INT = 8'h91; // Partial bit from state machine.
	localparam logic [7:0] CMD_FORCE_FAR_END_BLOCK_ERROR_BIT = 8'h92; // Force block error bit low.
	localparam int FILT_TLL_BIT = 1; // Triple-look enable within a filter code.
	localparam int FILT_CRC_BIT = 0; // CRC qualification within a filter code.
	localparam logic [1:0] FILT_DEF_NORM = 2'h2; // Triple look, non-repeater.
	localparam logic [1:0] FILT_DEF_RPT = 2'h1; // CRC qualified, repeater.

	// ------------------------------------------------------------------
	// Counters and controller register map
	// ------------------------------------------------------------------
	localparam int FAR_END_BLOCK_ERROR_BIT_CNT_W = 16; // Far-end block error counter width.
	localparam int ADDR_W = 4; // Software port address width.
	localparam logic [3:0] REG_TX = 4'h0; // Write: send overhead message.
	localparam logic [3:0] REG_CMD = 4'h4; // Write: send local command.
	localparam logic [3:0] REG_RX = 4'h8; // Read: last received bits.
	localparam logic [3:0] REG_STAT = 4'hc; // Read: new flag, cleared by read.

endpackage : ohb_pkg

// >>> core/ohb_link_if.sv
// Message channel between the overhead handler and its controller.
// Assumes one common clock; every signal changes right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
interface ohb_link_if;
	// Controller to device: overhead bits to transmit.
	logic ovh_wr_valid; // One-cycle pulse.
	logic [11:0] ovh_wr_bits; // Bit vector, M41 at bit 0.
	// Controller to device: local command message.
	logic cmd_valid; // One-cycle pulse.
	logic [7:0] cmd_hdr; // First byte.
	logic [7:0] cmd_code; // Second byte.
	// Device to controller: received overhead bits.
	logic ovh_rd_valid; // One-cycle pulse.
	logic [11:0] ovh_rd_bits; // Bit vector, M41 at bit 0.

	modport dev (
		input ovh_wr_valid, ovh_wr_bits, cmd_valid, cmd_hdr, cmd_code,
		output ovh_rd_valid, ovh_rd_bits
	);
	modport ctl (
		output ovh_wr_valid, ovh_wr_bits, cmd_valid, cmd_hdr, cmd_code,
		input ovh_rd_valid, ovh_rd_bits
	);
endinterface : ohb_link_if
`default_nettype wire

// >>> core/ohb_filter.sv
// Receive filter for one group of overhead bits.
// Assumes sf_tick pulses once per superframe with rx_bits valid beside it.
`timescale 1ns/10ps
`default_nettype none
module ohb_filter #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Superframe input.
	input wire logic sf_tick,
	input wire logic [W-1:0] rx_bits,
	input wire logic crc_clean,
	// Filter selection.
	input wire logic use_tll,
	input wire logic use_crc,
	input wire logic enable,
	// Filtered result.
	output logic report,
	output logic [W-1:0] value
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	if (W < 1) begin : g_bad_width
		$error("ohb_filter needs at least one bit");
	end

	typedef struct packed {
		logic [W-1:0] h1; // Value of the previous superframe.
		logic [W-1:0] h2; // Value two superframes back.
		logic [W-1:0] value; // Last reported value.
		logic report; // Pulse: value just changed.
	} ohb_filt_type;

	ohb_filt_type st_ff;
	ohb_filt_type nxt_st;
	logic stable; // Same value in three superframes in a row.

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// A change is taken only when every selected qualifier agrees.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.report = 1'b0;
		stable = (rx_bits == st_ff.h1) && (rx_bits == st_ff.h2);
		if (sf_tick) begin
			nxt_st.h1 = rx_bits;
			nxt_st.h2 = st_ff.h1;
			if (enable && (rx_bits != st_ff.value) &&
					(!use_tll || stable) &&
					(!use_crc || crc_clean)) begin
				nxt_st.value = rx_bits;
				nxt_st.report = 1'b1;
			end
		end
	end

	// History starts at all ones, the default of an idle line.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{h1: '1, h2: '1, value: '1, report: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign report = st_ff.report;
	assign value = st_ff.value;

endmodule : ohb_filter
`default_nettype wire

// >>> core/ohb_device.sv
// Overhead single-bit handler, device end of the message channel.
// Assumes all user-side inputs come from logic on the same clock and that
// sf_tick pulses once per superframe with rx and CRC inputs valid beside it.
`timescale 1ns/10ps
`default_nettype none
module ohb_device (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Controller channel.
	ohb_link_if.dev link,
	// Mode and state machine inputs.
	input wire logic repeater_mode,
	input wire logic test_entry,
	input wire logic act_bit,
	input wire logic deactivation_notice_bit,
	input wire logic partial_activation_bit,
	// Superframe receive side.
	input wire logic sf_tick,
	input wire logic crc_error,
	input wire logic rx_synced,
	input wire logic [11:0] rx_bits,
	// Transmit side and status.
	output logic [11:0] tx_bits,
	output logic [15:0] far_end_block_error_bit_count
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic part_ext; // Partial bit taken from messages.
		logic force_far_end_block_error_bit; // Send block error low once.
		logic m4_set; // M4 filter chosen by command.
		logic [1:0] m4_filt; // Chosen M4 filter code field.
		logic add_set; // Additional filter chosen by command.
		logic [1:0] add_filt; // Chosen additional filter code field.
		logic [11:0] user; // Bits latched from overhead messages.
		logic [11:0] tx; // Bits on the line this superframe.
		logic [1:0] crc_hist; // Violations in last two superframes.
		logic rx_far_end_block_error_bit; // Last received block error bit.
		logic [15:0] far_end_block_error_bit_cnt; // Received block error count.
		logic msg_valid; // Pulse: received message to controller.
		logic [11:0] msg_bits; // Received message contents.
	} ohb_dev_type;

	ohb_dev_type st_ff;
	ohb_dev_type nxt_st;

	// Filter outputs and effective filter selection.
	logic m4_report;
	logic [ohb_pkg::M4_W-1:0] m4_value;
	logic add_report;
	logic [ohb_pkg::ADD_W-1:0] add_value;
	logic [1:0] m4_mode;
	logic [1:0] add_mode;
	logic crc_clean;

	// ------------------------------------------------------------------
	// Command decoding
	// ------------------------------------------------------------------
	// True when a code falls in the four-code filter block at base.
	function automatic logic is_filter(input logic [7:0] code,
			input logic [7:0] base);
		is_filter = (code & ohb_pkg::CMD_FILT_MASK) == base;
	endfunction : is_filter

	// A filter not yet chosen by command follows the mode default.
	// Repeater mode may change at run time, so the default is looked up
	// continuously rather than loaded at reset.
	function automatic logic [1:0] eff_filter(input logic set,
			input logic [1:0] filt, input logic rpt);
		if (set) begin
			eff_filter = filt;
		end else if (rpt) begin
			eff_filter = ohb_pkg::FILT_DEF_RPT;
		end else begin
			eff_filter = ohb_pkg::FILT_DEF_NORM;
		end
	endfunction : eff_filter

	assign m4_mode = eff_filter(st_ff.m4_set, st_ff.m4_filt, repeater_mode);
	assign add_mode = eff_filter(st_ff.add_set, st_ff.add_filt,
		repeater_mode);
	// The superframe being judged is not counted in its own qualification.
	assign crc_clean = (st_ff.crc_hist == 2'h0);

	// ------------------------------------------------------------------
	// Receive filters
	// ------------------------------------------------------------------
	// The two groups keep separate history and separate selection.
	ohb_filter #(.W(ohb_pkg::M4_W)) u_m4_filter (
		.clock(clock),
		.rstn(rstn),
		.sf_tick(sf_tick),
		.rx_bits(rx_bits[ohb_pkg::M4_LSB +: ohb_pkg::M4_W]),
		.crc_clean(crc_clean),
		.use_tll(m4_mode[ohb_pkg::FILT_TLL_BIT]),
		.use_crc(m4_mode[ohb_pkg::FILT_CRC_BIT]),
		.enable(rx_synced),
		.report(m4_report),
		.value(m4_value)
	);

	ohb_filter #(.W(ohb_pkg::ADD_W)) u_add_filter (
		.clock(clock),
		.rstn(rstn),
		.sf_tick(sf_tick),
		.rx_bits(rx_bits[ohb_pkg::ADD_LSB +: ohb_pkg::ADD_W]),
		.crc_clean(crc_clean),
		.use_tll(add_mode[ohb_pkg::FILT_TLL_BIT]),
		.use_crc(add_mode[ohb_pkg::FILT_CRC_BIT]),
		.enable(rx_synced),
		.report(add_report),
		.value(add_value)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Commands, message latching, transmit assembly and receive reporting.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.msg_valid = 1'b0;

		// A forced block error is used up by the next superframe in any mode.
		// Clearing it ahead of the decode lets a command in that cycle win.
		if (sf_tick) begin
			nxt_st.force_far_end_block_error_bit = 1'b0;
		end

		// Entering the test state restores every command setting.
		if (test_entry) begin
			nxt_st.part_ext = 1'b0;
			nxt_st.force_far_end_block_error_bit = 1'b0;
			nxt_st.m4_set = 1'b0;
			nxt_st.add_set = 1'b0;
		end else if (link.cmd_valid &&
				link.cmd_hdr == ohb_pkg::CMD_HDR) begin
			if (is_filter(link.cmd_code, ohb_pkg::CMD_M4_BASE)) begin
				nxt_st.m4_set = 1'b1;
				nxt_st.m4_filt = link.cmd_code[1:0];
			end else if (is_filter(link.cmd_code,
					ohb_pkg::CMD_ADD_BASE)) begin
				nxt_st.add_set = 1'b1;
				nxt_st.add_filt = link.cmd_code[1:0];
			end else if (link.cmd_code == ohb_pkg::CMD_PART_EXT) begin
				nxt_st.part_ext = 1'b1;
			end else if (link.cmd_code == ohb_pkg::CMD_PART_INT) begin
				nxt_st.part_ext = 1'b0;
			end else if (link.cmd_code == ohb_pkg::CMD_FORCE_FAR_END_BLOCK_ERROR_BIT) begin
				nxt_st.force_far_end_block_error_bit = 1'b1;
			end
		end

		// Written bits are held and repeated until overwritten.
		if (link.ovh_wr_valid) begin
			nxt_st.user = link.ovh_wr_bits;
		end

		// The transmit word is rebuilt at each superframe boundary.
		if (sf_tick) begin
			nxt_st.tx = st_ff.user;
			if (!repeater_mode) begin
				nxt_st.tx[ohb_pkg::POS_M41] = act_bit;
				nxt_st.tx[ohb_pkg::POS_M42] =
					deactivation_notice_bit;
				if (!st_ff.part_ext) begin
					nxt_st.tx[ohb_pkg::POS_M47] =
						partial_activation_bit;
				end
				// Errors seen, or a forced test, send the bit low.
				nxt_st.tx[ohb_pkg::POS_M62] =
					!crc_error && !st_ff.force_far_end_block_error_bit;
			end
			nxt_st.crc_hist = {st_ff.crc_hist[0], crc_error};
			nxt_st.rx_far_end_block_error_bit = rx_bits[ohb_pkg::POS_M62];
			// The counter wraps; software reads differences.
			if (!rx_bits[ohb_pkg::POS_M62]) begin
				nxt_st.far_end_block_error_bit_cnt = st_ff.far_end_block_error_bit_cnt + 16'h0001;
			end
		end

		// Either group changing sends the whole received picture.
		if ((m4_report || add_report) && rx_synced) begin
			nxt_st.msg_valid = 1'b1;
			nxt_st.msg_bits = {st_ff.rx_far_end_block_error_bit, add_value, m4_value};
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Line bits and latched bits start as ones, as on an idle line.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{part_ext: 1'b0, force_far_end_block_error_bit: 1'b0, m4_set: 1'b0,
				m4_filt: 2'h0, add_set: 1'b0, add_filt: 2'h0,
				user: ohb_pkg::RST_TX_BITS, tx: ohb_pkg::RST_TX_BITS,
				crc_hist: 2'h0, rx_far_end_block_error_bit: 1'b1, far_end_block_error_bit_cnt: 16'h0000,
				msg_valid: 1'b0, msg_bits: ohb_pkg::RST_TX_BITS};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign tx_bits = st_ff.tx;
	assign far_end_block_error_bit_count = st_ff.far_end_block_error_bit_cnt;
	assign link.ovh_rd_valid = st_ff.msg_valid;
	assign link.ovh_rd_bits = st_ff.msg_bits;

endmodule : ohb_device
`default_nettype wire

// >>> core/ohb_controller.sv
// Controller end: turns software register accesses into channel messages.
// Assumes the software port is on the same clock and never strobes both.
`timescale 1ns/10ps
`default_nettype none
module ohb_controller (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Channel to the device.
	ohb_link_if.ctl link,
	// Software port.
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	// Status.
	output logic rx_pending
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic tx_valid; // Pulse: overhead message out.
		logic [11:0] tx_bits; // Bits of that message.
		logic cmd_valid; // Pulse: local command out.
		logic [7:0] cmd_code; // Code of that command.
		logic [11:0] rx_bits; // Last received bits.
		logic rx_new; // Sticky: a message arrived.
		logic [31:0] rdata; // Read data, valid one cycle.
	} ohb_ctl_type;

	ohb_ctl_type st_ff;
	ohb_ctl_type nxt_st;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tx_valid = 1'b0;
		nxt_st.cmd_valid = 1'b0;
		nxt_st.rdata = 32'h0000_0000;
		if (sw_wr && sw_addr == ohb_pkg::REG_TX) begin
			nxt_st.tx_valid = 1'b1;
			nxt_st.tx_bits = sw_wdata[11:0];
		end
		if (sw_wr && sw_addr == ohb_pkg::REG_CMD) begin
			nxt_st.cmd_valid = 1'b1;
			nxt_st.cmd_code = sw_wdata[7:0];
		end
		// Reads answer next cycle; unmapped addresses read zero.
		if (sw_rd) begin
			unique case (sw_addr)
				ohb_pkg::REG_RX: nxt_st.rdata = {20'h00000, st_ff.rx_bits};
				ohb_pkg::REG_STAT: begin
					nxt_st.rdata = {31'h0000_0000, st_ff.rx_new};
					nxt_st.rx_new = 1'b0;
				end
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
		// An arriving message beats a clearing read in the same cycle.
		if (link.ovh_rd_valid) begin
			nxt_st.rx_bits = link.ovh_rd_bits;
			nxt_st.rx_new = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{tx_valid: 1'b0, tx_bits: ohb_pkg::RST_TX_BITS,
				cmd_valid: 1'b0, cmd_code: 8'h00,
				rx_bits: ohb_pkg::RST_TX_BITS, rx_new: 1'b0,
				rdata: 32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign link.ovh_wr_valid = st_ff.tx_valid;
	assign link.ovh_wr_bits = st_ff.tx_bits;
	assign link.cmd_valid = st_ff.cmd_valid;
	assign link.cmd_hdr = ohb_pkg::CMD_HDR;
	assign link.cmd_code = st_ff.cmd_code;
	assign sw_rdata = st_ff.rdata;
	assign rx_pending = st_ff.rx_new;

endmodule : ohb_controller
`default_nettype wire

// >>> dv/ohb_chk.sv
// Checker for the overhead bit handler pair and its message channel.
// Assumes tb instantiates it beside the channel, all on one clock.
`timescale 1ns/10ps
`default_nettype none
module ohb_chk (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Channel signals.
	input wire logic ovh_wr_valid,
	input wire logic [11:0] ovh_wr_bits,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_hdr,
	input wire logic [7:0] cmd_code,
	input wire logic ovh_rd_valid,
	input wire logic [11:0] ovh_rd_bits,
	// Device line side.
	input wire logic repeater_mode,
	input wire logic test_entry,
	input wire logic act_bit,
	input wire logic deactivation_notice_bit,
	input wire logic partial_activation_bit,
	input wire logic sf_tick,
	input wire logic crc_error,
	input wire logic rx_synced,
	input wire logic [11:0] rx_bits,
	input wire logic [11:0] tx_bits,
	input wire logic [15:0] far_end_block_error_bit_count
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	logic [11:0] latched_ff; // Bits last written by the controller.
	logic ext_ff; // High while the partial bit comes from messages.

	// ------------------------------------------------------------------
	// Shadow of the latched bits and of the partial bit source.
	// ------------------------------------------------------------------
	// Commands sharing an edge with sf_tick are avoided by the bench.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			latched_ff <= ohb_pkg::RST_TX_BITS;
			ext_ff <= 1'b0;
		end else begin
			if (ovh_wr_valid)
				latched_ff <= ovh_wr_bits;
			if (test_entry)
				ext_ff <= 1'b0;
			else if (cmd_valid && cmd_code == ohb_pkg::CMD_PART_EXT)
				ext_ff <= 1'b1;
			else if (cmd_valid && cmd_code == ohb_pkg::CMD_PART_INT)
				ext_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Transmit side.
	// ------------------------------------------------------------------
	sequence s_tick_lt;
		sf_tick && !repeater_mode;
	endsequence

	a_act_from_sm: assert property (
		s_tick_lt |=> tx_bits[0] == $past(act_bit))
		else $error("activation bit not from state machine");
	a_deact_from_sm: assert property (
		s_tick_lt |=> tx_bits[1] == $past(deactivation_notice_bit))
		else $error("deactivation bit not from state machine");
	a_part_from_sm: assert property (
		sf_tick && !repeater_mode && !ext_ff
		|=> tx_bits[6] == $past(partial_activation_bit))
		else $error("partial bit not from state machine");
	a_far_end_block_error_bit_on_crc: assert property (
		s_tick_lt ##0 crc_error |=> !tx_bits[11])
		else $error("block error bit not low after crc error");
	a_lt_latched: assert property (
		sf_tick |=> (tx_bits & 12'h7bc) == ($past(latched_ff) & 12'h7bc))
		else $error("message positions not from latched bits");
	a_rpt_all_latched: assert property (
		sf_tick && repeater_mode |=> tx_bits == $past(latched_ff))
		else $error("repeater bits not all from messages");
	a_far_end_block_error_bit_count_step: assert property (
		far_end_block_error_bit_count == $past(far_end_block_error_bit_count)
		+ {15'h0, $past(sf_tick && !rx_bits[11])})
		else $error("block error counter step wrong");

	// ------------------------------------------------------------------
	// Receive side and commands.
	// ------------------------------------------------------------------
	a_rd_gated_sync: assert property (
		ovh_rd_valid |-> $past(sf_tick && rx_synced, 2) && $past(rx_synced))
		else $error("report without synced superframe");
	a_rd_one_pulse: assert property (
		ovh_rd_valid |=> !ovh_rd_valid)
		else $error("report pulse longer than one cycle");
	a_rd_far_end_block_error_bit_raw: assert property (
		ovh_rd_valid |-> ovh_rd_bits[11] == $past(rx_bits[11], 2))
		else $error("reported block error bit wrong");
	a_cmd_header: assert property (
		cmd_valid |-> cmd_hdr == ohb_pkg::CMD_HDR)
		else $error("command header byte wrong");
endmodule : ohb_chk
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench joining the controller and device ends.
// Assumes the package, the channel and both ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("unexpected %s expected %h seen %h", what, exp, got); \
	end \
end
module tb;
	// A row: line inputs {act, deact, part, crc, rx}, then the results.
	typedef struct packed {
		logic [15:0] line;
		logic [11:0] tx;
		logic [15:0] cnt;
	} ohb_row_type;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic repeater_mode = 1'b0;
	logic test_entry = 1'b0;
	logic act_bit = 1'b0;
	logic deactivation_notice_bit = 1'b0;
	logic partial_activation_bit = 1'b0;
	logic sf_tick = 1'b0;
	logic crc_error = 1'b0;
	logic rx_synced = 1'b0;
	logic [11:0] rx_bits = 12'hfff;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [11:0] tx_bits;
	logic [15:0] far_end_block_error_bit_count;
	logic [31:0] sw_rdata;
	logic rx_pending;
	logic [31:0] rd;
	logic [11:0] last_rep;
	int n_fail = 0;
	int cmp_count = 0;
	int n_rep = 0;
	// Latched bits are 0x5a5 while these rows run.
	ohb_row_type rows [4] = '{{16'he7ff, 12'hde7, 16'h1},
		{16'h1fff, 12'h5a4, 16'h1}, {16'ha7ff, 12'hde5, 16'h2},
		{16'h5fff, 12'h5a6, 16'h2}};

	ohb_link_if ohb_link_if_inst ();
	ohb_device ohb_device_inst (.clock(clock), .rstn(rstn),
		.link(ohb_link_if_inst), .repeater_mode(repeater_mode),
		.test_entry(test_entry), .act_bit(act_bit),
		.deactivation_notice_bit(deactivation_notice_bit),
		.partial_activation_bit(partial_activation_bit), .sf_tick(sf_tick),
		.crc_error(crc_error), .rx_synced(rx_synced), .rx_bits(rx_bits),
		.tx_bits(tx_bits), .far_end_block_error_bit_count(far_end_block_error_bit_count));
	ohb_controller ohb_controller_inst (.clock(clock), .rstn(rstn),
		.link(ohb_link_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.rx_pending(rx_pending));
	ohb_chk ohb_chk_inst (.clock(clock), .rstn(rstn),
		.ovh_wr_valid(ohb_link_if_inst.ovh_wr_valid),
		.ovh_wr_bits(ohb_link_if_inst.ovh_wr_bits),
		.cmd_valid(ohb_link_if_inst.cmd_valid),
		.cmd_hdr(ohb_link_if_inst.cmd_hdr),
		.cmd_code(ohb_link_if_inst.cmd_code),
		.ovh_rd_valid(ohb_link_if_inst.ovh_rd_valid),
		.ovh_rd_bits(ohb_link_if_inst.ovh_rd_bits),
		.repeater_mode(repeater_mode), .test_entry(test_entry),
		.act_bit(act_bit), .deactivation_notice_bit(deactivation_notice_bit),
		.partial_activation_bit(partial_activation_bit), .sf_tick(sf_tick),
		.crc_error(crc_error), .rx_synced(rx_synced), .rx_bits(rx_bits),
		.tx_bits(tx_bits), .far_end_block_error_bit_count(far_end_block_error_bit_count));

	// Clock at 200 MHz.
	always #2.5 clock = ~clock;

	// Count every report that reaches the controller.
	always @(posedge clock) begin
		if (ohb_link_if_inst.ovh_rd_valid === 1'b1) begin
			n_rep++;
			last_rep = ohb_link_if_inst.ovh_rd_bits;
		end
	end

	// ------------------------------------------------------------------
	// Bus and line tasks.
	// ------------------------------------------------------------------
	task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clock);
		sw_wr <= 1'b0;
	endtask : sw_write

	// Read data stand only in the cycle after the strobe.
	task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clock);
		sw_rd <= 1'b0;
		#1;
		d = sw_rdata;
	endtask : sw_read

	// One superframe; the tail keeps ticks apart and lets reports land.
	task automatic sf(input logic [15:0] s);
		@(posedge clock);
		{act_bit, deactivation_notice_bit, partial_activation_bit} <= s[15:13];
		crc_error <= s[12];
		rx_bits <= s[11:0];
		sf_tick <= 1'b1;
		@(posedge clock);
		sf_tick <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask : sf

	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		give_verdict();
	end

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		rx_synced <= 1'b1;
		#1;
		`CHK("tx_bits", 12'hfff, tx_bits)
		`CHK("far_end_block_error_bit_count", 16'h0, far_end_block_error_bit_count)
		`CHK("rx_pending", 1'b0, rx_pending)
		sw_read(ohb_pkg::REG_STAT, rd);
		`CHK("status", 32'h0, rd)
		sw_read(4'h2, rd);
		`CHK("unmapped", 32'h0, rd)
		sw_write(ohb_pkg::REG_TX, 32'h5a5);
		// Only the block error bit toggles on receive, so no report.
		foreach (rows[i]) begin
			sf(rows[i].line);
			`CHK("tx_bits", rows[i].tx, tx_bits)
			`CHK("far_end_block_error_bit_count", rows[i].cnt, far_end_block_error_bit_count)
		end
		`CHK("reports", 0, n_rep)
		sw_write(ohb_pkg::REG_CMD, {24'h0, ohb_pkg::CMD_PART_EXT});
		sw_write(ohb_pkg::REG_TX, 32'h0);
		sf(16'hefff);
		`CHK("tx_bits", 12'h803, tx_bits)
		sw_write(ohb_pkg::REG_CMD, {24'h0, ohb_pkg::CMD_PART_INT});
		sf(16'hefff);
		`CHK("tx_bits", 12'h843, tx_bits)
		sw_write(ohb_pkg::REG_CMD, {24'h0, ohb_pkg::CMD_FORCE_FAR_END_BLOCK_ERROR_BIT});
		sf(16'hefff);
		`CHK("tx_bits", 12'h043, tx_bits)
		sf(16'hefff);
		`CHK("tx_bits", 12'h843, tx_bits)
		// Test entry drops the settings, even a command in its cycle.
		sw_write(ohb_pkg::REG_CMD, {24'h0, ohb_pkg::CMD_PART_EXT});
		sw_write(ohb_pkg::REG_CMD, {24'h0, ohb_pkg::CMD_FORCE_FAR_END_BLOCK_ERROR_BIT});
		test_entry <= 1'b1;
		@(posedge clock);
		test_entry <= 1'b0;
		sf(16'hefff);
		`CHK("tx_bits", 12'h843, tx_bits)
		// On-change for M4: one change gives one report at once.
		sw_write(ohb_pkg::REG_CMD, 32'h8c);
		sf(16'heffe);
		`CHK("reports", 1, n_rep)
		`CHK("report bits", 12'hffe, last_rep)
		`CHK("rx_pending", 1'b1, rx_pending)
		sw_read(ohb_pkg::REG_STAT, rd);
		`CHK("status", 32'h1, rd)
		sw_read(ohb_pkg::REG_RX, rd);
		`CHK("rx reg", 32'hffe, rd)
		sw_read(ohb_pkg::REG_STAT, rd);
		`CHK("status", 32'h0, rd)
		`CHK("rx_pending", 1'b0, rx_pending)
		sf(16'he7fe);
		`CHK("reports", 1, n_rep)
		// Additional group keeps its triple-look default.
		sf(16'heefe);
		sf(16'heefe);
		`CHK("reports", 1, n_rep)
		sf(16'heefe);
		`CHK("reports", 2, n_rep)
		`CHK("report bits", 12'hefe, last_rep)
		// CRC only for M4: waits for two clean superframes.
		sw_write(ohb_pkg::REG_CMD, 32'h8d);
		sf(16'hfefe);
		sf(16'heefc);
		sf(16'heefc);
		`CHK("reports", 2, n_rep)
		sf(16'heefc);
		`CHK("reports", 3, n_rep)
		// Every filter code; the last one of each group leaves both groups combined.
		for (int c = 8'h88; c <= 8'h8f; c++)
			sw_write(ohb_pkg::REG_CMD, 32'(c));
		sf(16'heef0);
		sf(16'heef0);
		`CHK("reports", 3, n_rep)
		sf(16'heef0);
		`CHK("reports", 4, n_rep)
		// Unsynced receiver: changes are not reported.
		@(posedge clock);
		rx_synced <= 1'b0;
		sw_write(ohb_pkg::REG_CMD, 32'h8c);
		sf(16'heeff);
		`CHK("reports", 4, n_rep)
		// Repeater: every bit from messages; unmapped write ignored.
		@(posedge clock);
		repeater_mode <= 1'b1;
		sw_write(ohb_pkg::REG_TX, 32'h3c5);
		sw_write(4'h2, 32'h0);
		sf(16'hffff);
		`CHK("tx_bits", 12'h3c5, tx_bits)
		// Second reset in mid-run, then a release back to line mode.
		@(posedge clock);
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK("tx_bits", 12'hfff, tx_bits)
		`CHK("far_end_block_error_bit_count", 16'h0, far_end_block_error_bit_count)
		@(posedge clock);
		rstn <= 1'b1;
		repeater_mode <= 1'b0;
		sf(16'h0fff);
		`CHK("tx_bits", 12'hfbc, tx_bits)
		`CHK("rx_pending", 1'b0, rx_pending)
		give_verdict();
	end
endmodule : tb
`default_nettype wire
